// File: src/hbl_ctrl.sv
`timescale 1ns/100ps
module hbl_ctrl #(
  parameter logic [hbl_pkg::MATRIX_WORDS*hbl_pkg::WORD_W-1:0] WORDS = '0
) (
  input  wire logic                        clk,
  input  wire logic                        rst_b,
  input  wire logic                        power_ok,
  input  wire logic                        boot_go,
  input  wire logic                        cycle_end_pulse,
  input  wire logic                        first_time_state,
  input  wire logic                        third_time_state,
  input  wire logic [hbl_pkg::WORD_W-1:0]  init_jumper_fitted,
  input  wire logic [hbl_pkg::WORD_W-1:0]  start_jumper_fitted,
  input  wire logic [hbl_pkg::BANK_W-1:0]  bank_bits,
  output logic [hbl_pkg::WORD_W-1:0]       data_bus_out,
  output logic                             data_bus_oe,
  output logic                             deposit_ir_inhibit,
  output logic                             load_addr_enable,
  output logic                             load_addr_pulse,
  output logic                             key_control,
  output logic                             mem_start,
  output logic                             mem_run_pulse,
  output logic                             halt_request,
  output logic                             bank_to_bus_enable,
  output logic                             loader_active
);
  typedef struct packed {
    logic [2:0] pok_s;
    logic [2:0] go_s;
    logic       pok_f;
    logic       go_f;
    logic       final_word;
    logic       active;
    logic       deposit_flag;
    logic       second;
    logic       field;
    logic       data;
    logic       dumping;
    logic       run_pulse;
  } hbl_ctl_t;
  hbl_ctl_t st_reg;
  hbl_ctl_t st_next;
  logic d2_trig;
  logic d2_busy;
  logic d2_done;
  logic d3_trig;
  logic d3_busy;
  logic d3_done;
  logic d4_busy;
  logic d4_done;
  logic strobe_end;
  logic dump_end;
  logic loader_clear;
  logic init_select;
  hbl_if lnk ();
  // ==========================================================
  // Delay chain.
  hbl_delay #(.LEN(hbl_pkg::D2_CYCLES)) u_d2 (
    .clk   (clk),
    .rst_b (rst_b),
    .trig  (d2_trig),
    .busy  (d2_busy),
    .done  (d2_done)
  );
  hbl_delay #(.LEN(hbl_pkg::D3_CYCLES)) u_d3 (
    .clk   (clk),
    .rst_b (rst_b),
    .trig  (d3_trig),
    .busy  (d3_busy),
    .done  (d3_done)
  );
  hbl_delay #(.LEN(hbl_pkg::D4_CYCLES)) u_d4 (
    .clk   (clk),
    .rst_b (rst_b),
    .trig  (d3_done),
    .busy  (d4_busy),
    .done  (d4_done)
  );
  hbl_matrix #(.WORDS(WORDS)) u_mat (
    .clk                 (clk),
    .rst_b               (rst_b),
    .init_jumper_fitted  (init_jumper_fitted),
    .start_jumper_fitted (start_jumper_fitted),
    .bank_bits           (bank_bits),
    .lnk                 (lnk)
  );
  // ==========================================================
  // Sequencing events.
  // A held switch is only seen once, on its filtered rising edge.
  assign d2_trig = st_next.go_f && !st_reg.go_f && !st_reg.active
                   && st_reg.pok_f;
  assign strobe_end = d4_done && st_reg.active && !st_reg.data;
  assign dump_end = cycle_end_pulse && st_reg.dumping
                    && lnk.last_word;
  assign d3_trig = d2_done || strobe_end || dump_end;
  assign loader_clear = !st_reg.active || dump_end;
  assign init_select = st_reg.active && !st_reg.field
                       && !st_reg.second;
  always_comb
  begin
    st_next = st_reg;
    st_next.pok_s = {st_reg.pok_s[1:0], power_ok};
    st_next.go_s  = {st_reg.go_s[1:0], boot_go};
    if (st_reg.pok_s[1] == st_reg.pok_s[2])
      st_next.pok_f = st_reg.pok_s[2];
    if (st_reg.go_s[1] == st_reg.go_s[2])
      st_next.go_f = st_reg.go_s[2];
    st_next.run_pulse = d4_done && st_reg.active && st_reg.data;
    if (d2_done)
    begin
      st_next.active       = 1'b1;
      st_next.deposit_flag = 1'b1;
      // A new boot must not inherit the halt of the previous one.
      st_next.final_word   = 1'b0;
    end
    if (strobe_end)
    begin
      if (!st_reg.field)
        st_next.field = 1'b1;
      else
        st_next.data = 1'b1;
    end
    if (st_reg.run_pulse)
    begin
      if (!st_reg.second)
      begin
        st_next.second  = 1'b1;
        st_next.dumping = 1'b1;
      end
      else
        st_next.active = 1'b0;
    end
    if (dump_end)
    begin
      st_next.final_word = 1'b1;
      st_next.dumping    = 1'b0;
    end
    if (loader_clear)
    begin
      st_next.field = 1'b0;
      st_next.data  = 1'b0;
    end
    if (!st_reg.active)
    begin
      st_next.second  = 1'b0;
      st_next.dumping = 1'b0;
    end
    if (!st_reg.pok_f)
    begin
      st_next.final_word   = 1'b0;
      st_next.active       = 1'b0;
      st_next.deposit_flag = 1'b0;
    end
  end
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      st_reg <= '0;
    else
      st_reg <= st_next;
  end
  // ==========================================================
  // Matrix link and bus outputs.
  assign lnk.loader_clear       = loader_clear;
  assign lnk.advance            = st_reg.run_pulse && !st_reg.second
                                  && !st_reg.dumping;
  assign lnk.cycle_end_pulse    = cycle_end_pulse;
  assign lnk.dump_en            = st_reg.dumping;
  assign lnk.bank_to_bus_enable = bank_to_bus_enable;
  assign lnk.init_sel_n         = !init_select;
  assign lnk.start_sel_n        = !(st_reg.active && !st_reg.field
                                    && st_reg.second);
  assign bank_to_bus_enable = st_reg.active && st_reg.field
                              && !st_reg.data;
  assign load_addr_enable   = st_reg.active && !st_reg.data;
  assign load_addr_pulse    = d4_busy && load_addr_enable;
  assign mem_start          = d4_busy && st_reg.active
                              && st_reg.data;
  assign mem_run_pulse      = st_reg.run_pulse;
  // Key control drops in the third time state so the processor runs on.
  assign key_control = bank_to_bus_enable
                       || (st_reg.dumping && !third_time_state);
  assign deposit_ir_inhibit = st_reg.deposit_flag && st_reg.active;
  assign halt_request = st_reg.active && st_reg.final_word;
  assign loader_active = st_reg.active;
  assign data_bus_out  = lnk.bus_word;
  assign data_bus_oe   = st_reg.active && (load_addr_enable
                         || st_reg.dumping);
  // ==========================================================
  // Checks.
  property p_pok_clear;
    @(posedge clk) disable iff (!rst_b)
      !st_reg.pok_f |=> !st_reg.active && !st_reg.deposit_flag
                        && !st_reg.final_word;
  endproperty
  a_pok_clear: assert property (p_pok_clear)
    else $error("Power-good low did not clear flags.");
  property p_second_clear;
    @(posedge clk) disable iff (!rst_b)
      !st_reg.active ##1 !st_reg.active |-> !st_reg.second;
  endproperty
  a_second_clear: assert property (p_second_clear)
    else $error("Second-pass flag set while inactive.");
  property p_d2_sets;
    @(posedge clk) disable iff (!rst_b)
      d2_done && st_reg.pok_f |=> st_reg.active && st_reg.deposit_flag
                                  && d3_busy;
  endproperty
  a_d2_sets: assert property (p_d2_sets)
    else $error("Stage two did not start the loader.");
  property p_init_sel;
    @(posedge clk) disable iff (!rst_b)
      !lnk.init_sel_n |-> lnk.start_sel_n && !st_reg.second;
  endproperty
  a_init_sel: assert property (p_init_sel)
    else $error("Initial select with second pass.");
  property p_no_strobe_data;
    @(posedge clk) disable iff (!rst_b)
      st_reg.data |-> !load_addr_pulse && !load_addr_enable;
  endproperty
  a_no_strobe_data: assert property (p_no_strobe_data)
    else $error("Load strobe in data phase.");
  property p_retrigger;
    @(posedge clk) disable iff (!rst_b)
      strobe_end |=> d3_busy ##[1:20] d4_busy;
  endproperty
  a_retrigger: assert property (p_retrigger)
    else $error("Chain not retriggered after strobe.");
  property p_run_after_start;
    @(posedge clk) disable iff (!rst_b)
      $rose(mem_run_pulse) |-> $past(mem_start);
  endproperty
  a_run_after_start: assert property (p_run_after_start)
    else $error("Memory-run strobe without memory start.");
  property p_second_set;
    @(posedge clk) disable iff (!rst_b)
      mem_run_pulse && !st_reg.second && st_reg.active && st_reg.pok_f
      |=> st_reg.second && st_reg.dumping;
  endproperty
  a_second_set: assert property (p_second_set)
    else $error("First memory run did not set second pass.");
  property p_finish;
    @(posedge clk) disable iff (!rst_b)
      mem_run_pulse && st_reg.second |=> !st_reg.active ##1 !data_bus_oe;
  endproperty
  a_finish: assert property (p_finish)
    else $error("Second memory run did not end the loader.");
  property p_halt;
    @(posedge clk) disable iff (!rst_b)
      dump_end && st_reg.pok_f |=> halt_request && !st_reg.data;
  endproperty
  a_halt: assert property (p_halt)
    else $error("Dump end did not raise halt.");
  property p_field_set;
    @(posedge clk) disable iff (!rst_b)
      strobe_end && !st_reg.field |=> st_reg.field;
  endproperty
  a_field_set: assert property (p_field_set)
    else $error("First load strobe did not set the field flag.");
  property p_run_strobe;
    @(posedge clk) disable iff (!rst_b)
      $fell(mem_start) && st_reg.active |-> mem_run_pulse;
  endproperty
  a_run_strobe: assert property (p_run_strobe)
    else $error("Memory start ended without a memory-run strobe.");
  property p_dump_restart;
    @(posedge clk) disable iff (!rst_b)
      dump_end |=> !st_reg.field && !st_reg.data && d3_busy;
  endproperty
  a_dump_restart: assert property (p_dump_restart)
    else $error("Dump end did not clear phases and restart the chain.");
  property p_bank_bus;
    @(posedge clk) disable iff (!rst_b)
      bank_to_bus_enable |=> data_bus_out == {9'h000, bank_bits};
  endproperty
  a_bank_bus: assert property (p_bank_bus)
    else $error("Bank bits missing from the bus in the field phase.");
  property p_init_word;
    @(posedge clk) disable iff (!rst_b)
      !lnk.init_sel_n |=> data_bus_out == ~init_jumper_fitted;
  endproperty
  a_init_word: assert property (p_init_word)
    else $error("Initial address not driven from the jumpers.");
  property p_key_hold;
    @(posedge clk) disable iff (!rst_b)
      st_reg.dumping && first_time_state |-> key_control;
  endproperty
  a_key_hold: assert property (p_key_hold)
    else $error("Key control missing in the first time state.");
  property p_key_release;
    @(posedge clk) disable iff (!rst_b)
      st_reg.dumping && third_time_state |-> !key_control;
  endproperty
  a_key_release: assert property (p_key_release)
    else $error("Key control held in the third time state.");
  c_start: cover property (@(posedge clk) disable iff (!rst_b) d2_done);
  c_dump: cover property (@(posedge clk) disable iff (!rst_b)
    $rose(st_reg.dumping));
  c_end: cover property (@(posedge clk) disable iff (!rst_b) dump_end);
  c_done: cover property (@(posedge clk) disable iff (!rst_b)
    $fell(st_reg.active) && st_reg.final_word);
endmodule : hbl_ctrl

// File: src/hbl_pkg.sv
package hbl_pkg;
  // ==========================================================
  // Sizes and timing.
  localparam int WORD_W        = 12;
  localparam int BANK_W        = 3;
  localparam int MATRIX_WORDS  = 32;
  localparam int CLK_PERIOD_NS = 100;
  localparam int T_D2_NS       = 180;
  localparam int T_D3_NS       = 500;
  localparam int T_D4_NS       = 300;
  localparam int D2_CYCLES = (T_D2_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int D3_CYCLES = (T_D3_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int D4_CYCLES = (T_D4_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int DLY_CNT_W = 8;
  localparam logic [WORD_W-1:0] BUS_IDLE = 12'h000;
endpackage : hbl_pkg

// File: src/hbl_if.sv
`timescale 1ns/100ps
interface hbl_if;
  logic                        loader_clear;
  logic                        advance;
  logic                        cycle_end_pulse;
  logic                        dump_en;
  logic                        bank_to_bus_enable;
  logic                        init_sel_n;
  logic                        start_sel_n;
  logic                        last_word;
  logic [hbl_pkg::WORD_W-1:0]  bus_word;
  modport ctrl (
    output loader_clear,
    output advance,
    output cycle_end_pulse,
    output dump_en,
    output bank_to_bus_enable,
    output init_sel_n,
    output start_sel_n,
    input  last_word,
    input  bus_word
  );
  modport mat (
    input  loader_clear,
    input  advance,
    input  cycle_end_pulse,
    input  dump_en,
    input  bank_to_bus_enable,
    input  init_sel_n,
    input  start_sel_n,
    output last_word,
    output bus_word
  );
endinterface : hbl_if

// File: src/hbl_delay.sv
`timescale 1ns/100ps
module hbl_delay #(
  parameter int LEN = 2
) (
  input  wire logic clk,
  input  wire logic rst_b,
  input  wire logic trig,
  output logic      busy,
  output logic      done
);
  typedef struct packed {
    logic [hbl_pkg::DLY_CNT_W-1:0] cnt;
  } hbl_dly_t;
  hbl_dly_t st_reg;
  hbl_dly_t st_next;
  localparam logic [hbl_pkg::DLY_CNT_W-1:0] LEN_C =
    hbl_pkg::DLY_CNT_W'(LEN);
  // ==========================================================
  // A trigger reloads the count, so the stage is retriggerable.
  always_comb
  begin
    st_next = st_reg;
    if (trig)
      st_next.cnt = LEN_C;
    else if (st_reg.cnt != '0)
      st_next.cnt = st_reg.cnt - 8'h01;
  end
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      st_reg <= '0;
    else
      st_reg <= st_next;
  end
  assign busy = (st_reg.cnt != '0);
  assign done = (st_reg.cnt == 8'h01) && !trig;
endmodule : hbl_delay

// File: src/hbl_matrix.sv
`timescale 1ns/100ps
module hbl_matrix #(
  parameter logic [hbl_pkg::MATRIX_WORDS*hbl_pkg::WORD_W-1:0] WORDS = '0
) (
  input  wire logic                         clk,
  input  wire logic                         rst_b,
  input  wire logic [hbl_pkg::WORD_W-1:0]   init_jumper_fitted,
  input  wire logic [hbl_pkg::WORD_W-1:0]   start_jumper_fitted,
  input  wire logic [hbl_pkg::BANK_W-1:0]   bank_bits,
  hbl_if.mat                                lnk
);
  typedef struct packed {
    logic [hbl_pkg::MATRIX_WORDS-1:0] onehot;
    logic [hbl_pkg::WORD_W-1:0]       word;
  } hbl_mat_t;
  hbl_mat_t st_reg;
  hbl_mat_t st_next;
  // ==========================================================
  // Overlapping ones would OR words together; the one-hot shift avoids it.
  function automatic logic [hbl_pkg::WORD_W-1:0] pick(
    input logic [hbl_pkg::MATRIX_WORDS-1:0] sel
  );
    logic [hbl_pkg::WORD_W-1:0] w;
    w = '0;
    for (int i = 0; i < hbl_pkg::MATRIX_WORDS; i++)
      if (sel[i])
        w = w | WORDS[i*hbl_pkg::WORD_W +: hbl_pkg::WORD_W];
    return w;
  endfunction : pick
  always_comb
  begin
    st_next = st_reg;
    if (lnk.loader_clear)
      st_next.onehot = '0;
    else if (lnk.advance && st_reg.onehot == '0)
      st_next.onehot = 32'h0000_0001;
    else if (lnk.cycle_end_pulse && lnk.dump_en)
      st_next.onehot = {st_reg.onehot[30:0], 1'b0};
    if (lnk.bank_to_bus_enable)
      st_next.word = {9'h000, bank_bits};
    else if (lnk.dump_en)
      st_next.word = pick(st_next.onehot);
    else if (!lnk.init_sel_n)
      st_next.word = ~init_jumper_fitted;
    else if (!lnk.start_sel_n)
      st_next.word = ~start_jumper_fitted;
    else
      st_next.word = hbl_pkg::BUS_IDLE;
  end
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      st_reg <= '0;
    else
      st_reg <= st_next;
  end
  property p_onehot;
    @(posedge clk) disable iff (!rst_b)
      $onehot0(st_reg.onehot);
  endproperty
  a_onehot: assert property (p_onehot)
    else $error("Word select holds more than one bit.");
  assign lnk.bus_word  = st_reg.word;
  assign lnk.last_word = st_reg.onehot[31];
endmodule : hbl_matrix

// File: test/hbl_cpu_model.sv
`timescale 1ns/100ps
// ==========================================================
// Processor side: memory cycles, address loads and deposits.
module hbl_cpu_model (
  input  wire logic                       clk,
  input  wire logic                       rst_b,
  input  wire logic                       power_ok,
  input  wire logic                       mem_start,
  input  wire logic                       mem_run_pulse,
  input  wire logic                       halt_request,
  input  wire logic                       load_addr_pulse,
  input  wire logic                       load_addr_enable,
  input  wire logic                       deposit_ir_inhibit,
  input  wire logic                       key_control,
  input  wire logic                       data_bus_oe,
  input  wire logic [hbl_pkg::WORD_W-1:0] data_bus_out,
  output logic                            cycle_end_pulse,
  output logic                            first_time_state,
  output logic                            third_time_state
);
  logic                       run_reg;
  logic [2:0]                 phase_reg;
  logic                       pulse_q;
  logic                       dumping;
  logic [hbl_pkg::WORD_W-1:0] held_word;
  logic [hbl_pkg::WORD_W-1:0] loads[$];
  logic [hbl_pkg::WORD_W-1:0] deps[$];
  int                         n_run;
  int                         n_halt;
  int                         n_key_bad;
  int                         n_key_on;

  assign dumping = deposit_ir_inhibit && data_bus_oe && !load_addr_enable;
  // Eight clocks per memory cycle leave the new word time to settle.
  assign cycle_end_pulse  = run_reg && phase_reg == 3'h7;
  assign first_time_state = run_reg && phase_reg[2:1] == 2'h0;
  assign third_time_state = run_reg && phase_reg[2:1] == 2'h2;

  always @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      run_reg   <= 1'b0;
      phase_reg <= 3'h0;
      pulse_q   <= 1'b0;
    end
    else
    begin
      // A power loss stops the processor as it would the real one.
      run_reg <= power_ok && (mem_start || (run_reg && !halt_request));
      phase_reg <= run_reg ? phase_reg + 3'h1 : 3'h0;
      pulse_q   <= load_addr_pulse;
      if (load_addr_pulse)
        held_word <= data_bus_out;
      if (pulse_q && !load_addr_pulse)
        loads.push_back(held_word);
      if (cycle_end_pulse && dumping)
        deps.push_back(data_bus_out);
      if (mem_run_pulse)
        n_run++;
      if (halt_request)
        n_halt++;
      if (dumping && third_time_state && key_control)
        n_key_bad++;
      if (dumping && first_time_state && key_control)
        n_key_on++;
    end
  end
endmodule : hbl_cpu_model

// File: test/tb_top.sv
`timescale 1ns/100ps
`define CHK(g, e) check_val(32'(g), 32'(e))
// ==========================================================
// Boot sequence bench with a processor model on the far side.
module tb_top;
  localparam int NW = hbl_pkg::MATRIX_WORDS;
  localparam int WW = hbl_pkg::WORD_W;

  function automatic logic [WW-1:0] word_at(input int i);
    return WW'(i * 273) ^ 12'h805;
  endfunction : word_at

  function automatic logic [NW*WW-1:0] mk_words();
    logic [NW*WW-1:0] w;
    w = '0;
    for (int i = 0; i < NW; i++)
      w[WW*i+:WW] = word_at(i);
    return w;
  endfunction : mk_words

  logic              clk;
  logic              rst_b;
  logic              power_ok;
  logic              boot_go;
  logic              cyc_end;
  logic              ts_one;
  logic              ts_three;
  logic [WW-1:0]     init_j;
  logic [WW-1:0]     start_j;
  logic [2:0]        bank;
  logic [WW-1:0]     dbus;
  logic              dbus_oe;
  logic              dep_inh;
  logic              la_en;
  logic              la_pulse;
  logic              key_ctl;
  logic              mstart;
  logic              mrun;
  logic              halt;
  logic              bank_en;
  logic              loader_active;
  int                n_fail;
  int                n_tests;
  int                seed;

  hbl_ctrl #(.WORDS(mk_words())) dut_u (
    .clk(clk), .rst_b(rst_b), .power_ok(power_ok), .boot_go(boot_go),
    .cycle_end_pulse(cyc_end), .first_time_state(ts_one),
    .third_time_state(ts_three), .init_jumper_fitted(init_j),
    .start_jumper_fitted(start_j), .bank_bits(bank),
    .data_bus_out(dbus), .data_bus_oe(dbus_oe),
    .deposit_ir_inhibit(dep_inh), .load_addr_enable(la_en),
    .load_addr_pulse(la_pulse), .key_control(key_ctl),
    .mem_start(mstart), .mem_run_pulse(mrun), .halt_request(halt),
    .bank_to_bus_enable(bank_en), .loader_active(loader_active));

  hbl_cpu_model cpu_u (
    .clk(clk), .rst_b(rst_b), .power_ok(power_ok), .mem_start(mstart),
    .mem_run_pulse(mrun), .halt_request(halt), .load_addr_pulse(la_pulse),
    .load_addr_enable(la_en), .deposit_ir_inhibit(dep_inh),
    .key_control(key_ctl), .data_bus_oe(dbus_oe), .data_bus_out(dbus),
    .cycle_end_pulse(cyc_end), .first_time_state(ts_one),
    .third_time_state(ts_three));

  always #50 clk = ~clk;

  task automatic check_val(input logic [31:0] g, input logic [31:0] e);
    n_tests++;
    if (g !== e)
    begin
      n_fail++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : check_val

  task automatic complete_run();
    $display("Checks %0d, mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : complete_run

  task automatic wait_deps(input int n);
    int k;
    for (k = 0; k < 3000 && cpu_u.deps.size() < n; k++)
      @(posedge clk);
    if (cpu_u.deps.size() < n)
    begin
      n_fail++;
      complete_run();
    end
  endtask : wait_deps

  task automatic wait_active(input logic lvl);
    int k;
    for (k = 0; k < 3000 && loader_active !== lvl; k++)
      @(posedge clk);
    if (loader_active !== lvl)
    begin
      n_fail++;
      complete_run();
    end
  endtask : wait_active

  // Fresh straps, a settled power line, then a boot switch edge.
  task automatic start_boot();
    cpu_u.loads.delete();
    cpu_u.deps.delete();
    cpu_u.n_run = 0;
    cpu_u.n_halt = 0;
    cpu_u.n_key_bad = 0;
    cpu_u.n_key_on = 0;
    @(posedge clk);
    init_j   <= WW'($random(seed));
    start_j  <= WW'($random(seed));
    bank     <= 3'($random(seed));
    power_ok <= 1'b1;
    repeat (8) @(posedge clk);
    boot_go <= 1'b1;
    wait_active(1'b1);
    boot_go <= 1'b0;
    `CHK(dep_inh, 1);
  endtask : start_boot

  task automatic full_run();
    start_boot();
    wait_deps(5);
    // A second switch edge while busy must not restart anything.
    boot_go <= 1'b1;
    repeat (10) @(posedge clk);
    boot_go <= 1'b0;
    wait_active(1'b0);
    repeat (2) @(posedge clk);
    `CHK(cpu_u.loads.size(), 4);
    `CHK(cpu_u.loads[0], WW'(~init_j));
    `CHK(cpu_u.loads[1][2:0], bank);
    `CHK(cpu_u.loads[2], WW'(~start_j));
    `CHK(cpu_u.loads[3][2:0], bank);
    `CHK(cpu_u.deps.size(), NW);
    for (int i = 0; i < NW && i < cpu_u.deps.size(); i++)
      `CHK(cpu_u.deps[i], word_at(i));
    `CHK(cpu_u.n_run, 2);
    `CHK(cpu_u.n_halt > 0, 1);
    `CHK(cpu_u.n_key_bad, 0);
    `CHK(cpu_u.n_key_on > 0, 1);
    `CHK(dbus_oe, 0);
    `CHK(halt, 0);
  endtask : full_run

  initial
  begin
    clk      = 1'b0;
    rst_b    = 1'b0;
    power_ok = 1'b1;
    boot_go  = 1'b0;
    init_j   = '0;
    start_j  = '0;
    bank     = '0;
    n_fail   = 0;
    n_tests  = 0;
    seed     = 36;
    repeat (20) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    `CHK(loader_active, 0);
    `CHK(dbus_oe, 0);
    full_run();
    // Power loss in mid-dump drops the loader off the bus.
    start_boot();
    wait_deps(3);
    power_ok <= 1'b0;
    repeat (12) @(posedge clk);
    `CHK(loader_active, 0);
    `CHK(dep_inh, 0);
    `CHK(halt, 0);
    `CHK(la_en, 0);
    `CHK(dbus_oe, 0);
    `CHK(bank_en, 0);
    full_run();
    complete_run();
  end
endmodule : tb_top
